/* File: rtl/pusel_defs.vh */
`ifndef PUSEL_DEFS_VH
`define PUSEL_DEFS_VH

// Register byte offsets
`define PUSEL_REG_CMD 6'h00
`define PUSEL_REG_ARG 6'h04
`define PUSEL_REG_VLIM 6'h08
`define PUSEL_REG_ILIM 6'h0C
`define PUSEL_REG_STATUS 6'h10
`define PUSEL_REG_VOUT 6'h14
`define PUSEL_REG_IOUT 6'h18
`define PUSEL_REG_SETPT 6'h1C
`define PUSEL_REG_SWLIM 6'h20

// Command codes written to the command register
`define PUSEL_CMD_OUT_ON 4'h1
`define PUSEL_CMD_OUT_OFF 4'h2
`define PUSEL_CMD_OUT_CTRL 4'h3
`define PUSEL_CMD_MODE 4'h4
`define PUSEL_CMD_VPROT_SRC 4'h5
`define PUSEL_CMD_IPROT_SRC 4'h6
`define PUSEL_CMD_MAIN_SRC 4'h7
`define PUSEL_CMD_SAVE_INT 4'h8
`define PUSEL_CMD_SAVE_LIM 4'h9
`define PUSEL_CMD_SAVE_LOC 4'hA

// Arguments
`define PUSEL_ARG_VOLT 2'h0
`define PUSEL_ARG_CURR 2'h1
`define PUSEL_ARG_OUTSIDE 2'h2
`define PUSEL_PROT_FIXED 2'h0
`define PUSEL_PROT_EXT 2'h1
`define PUSEL_PROT_LESS 2'h2
`define PUSEL_OUTCTL_TRIG 1'b1

// Status fields
`define PUSEL_ST_MODE 0
`define PUSEL_ST_OUT 1
`define PUSEL_ST_TRIG 2
`define PUSEL_ST_EXTREF 3
`define PUSEL_ST_EXTOK 4

// Limit codes: full scale, 1.01 x full scale, minimum
`define PUSEL_LIM_RATED 16'h2710
`define PUSEL_LIM_MAX 16'h2774
`define PUSEL_LIM_MIN 16'h03E8

`endif

/* File: rtl/pusel_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "pusel_defs.vh"
module pusel_top #(
  parameter LIM_W = 16,
  parameter NLOC = 16
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire [4:0] i_power_up_switch_bank,
  input wire i_reset_power_up,
  input wire i_trigger_pin,
  input wire i_mode_pin,
  input wire [LIM_W-1:0] i_ext_vlim_pos,
  input wire [LIM_W-1:0] i_ext_vlim_neg,
  input wire [LIM_W-1:0] i_ext_ilim_pos,
  input wire [LIM_W-1:0] i_ext_ilim_neg,
  input wire signed [LIM_W-1:0] i_ext_reference,
  output reg o_output_on,
  output reg o_current_mode,
  output reg o_ext_reference_used,
  output reg signed [LIM_W-1:0] o_setpoint,
  output reg [LIM_W-1:0] o_prot_pos,
  output reg [LIM_W-1:0] o_prot_neg
);
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  reg [2:0] trig_s_q;
  reg [2:0] mode_s_q;
  reg trig_q;
  reg mpin_q;
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      trig_s_q <= 3'h7;
      mode_s_q <= 3'h7;
      trig_q <= 1'b1;
      mpin_q <= 1'b1;
    end else if (i_ce) begin
      trig_s_q <= {trig_s_q[1:0], i_trigger_pin};
      mode_s_q <= {mode_s_q[1:0], i_mode_pin};
      if (trig_s_q[1] == trig_s_q[2])
        trig_q <= trig_s_q[2];
      if (mode_s_q[1] == mode_s_q[2])
        mpin_q <= mode_s_q[2];
    end
  end

  // Nonvolatile copies: i_rst_n leaves them alone so a power cycle can restore them;
  // they hold unknowns until the first reset power-up writes the factory defaults
  wire [NLOC-1:0] nv_mode_w;
  wire [NLOC-1:0] nv_extref_w;
  wire [2*NLOC-1:0] nv_vsrc_w;
  wire [2*NLOC-1:0] nv_isrc_w;
  wire [NLOC-1:0] nv_mfollow_w;
  wire [LIM_W*NLOC-1:0] nv_vlim_w;
  wire [LIM_W*NLOC-1:0] nv_ilim_w;
  reg nv_outctl_q;
  reg [LIM_W-1:0] nv_swlim_q;

  // Runtime state
  reg cur_mode_q;
  reg mode_follow_q;
  reg extref_q;
  reg extref_ok_q;
  reg [1:0] vsrc_q;
  reg [1:0] isrc_q;
  reg [1:0] fixed_q;
  reg fixed_en_q;
  reg outctl_q;
  reg out_cmd_q;
  reg [LIM_W-1:0] vlim_q;
  reg [LIM_W-1:0] ilim_q;
  reg [LIM_W-1:0] swlim_q;
  reg signed [LIM_W-1:0] dsetpt_q;
  reg [3:0] arg_q;
  reg cfg_done_q;

  wire [4:0] sw = i_power_up_switch_bank;
  wire [3:0] loc = sw[3:0];
  wire cmd_wr = i_avs_write && !o_avs_waitrequest && i_ce &&
    (i_avs_address == `PUSEL_REG_CMD);
  wire [3:0] cmd = i_avs_writedata[3:0];
  wire [3:0] cmd_loc = arg_q;
  // Factory defaults reach every copy at the sampling edge of a reset power-up
  wire nv_clear = i_ce && i_rst_n && !cfg_done_q && i_reset_power_up;
  // save numbered location; a save never writes location 0
  wire save_loc_we = cmd_wr && i_rst_n && cfg_done_q && (cmd == `PUSEL_CMD_SAVE_LOC) &&
    (cmd_loc != 4'h0);
  wire [NLOC-1:0] save_hot = save_loc_we ?
    ({{(NLOC-1){1'b0}}, 1'b1} << cmd_loc) : {NLOC{1'b0}};
  genvar g;
  generate
    for (g = 0; g < NLOC; g = g + 1) begin : g_loc
      reg mode_e_q;
      reg mfollow_e_q;
      reg extref_e_q;
      reg [1:0] vsrc_e_q;
      reg [1:0] isrc_e_q;
      reg [LIM_W-1:0] vlim_e_q;
      reg [LIM_W-1:0] ilim_e_q;
      always @(posedge i_core_clk) begin
        if (nv_clear) begin
          mode_e_q <= 1'b0;
          mfollow_e_q <= 1'b0;
          extref_e_q <= 1'b0;
          vsrc_e_q <= `PUSEL_PROT_FIXED;
          isrc_e_q <= `PUSEL_PROT_FIXED;
          vlim_e_q <= `PUSEL_LIM_RATED;
          ilim_e_q <= `PUSEL_LIM_RATED;
        end else if (save_hot[g]) begin
          mode_e_q <= cur_mode_q;
          mfollow_e_q <= mode_follow_q;
          extref_e_q <= extref_q;
          vsrc_e_q <= vsrc_q;
          isrc_e_q <= isrc_q;
          vlim_e_q <= vlim_q;
          ilim_e_q <= ilim_q;
        end
      end
      assign nv_mode_w[g] = mode_e_q;
      assign nv_mfollow_w[g] = mfollow_e_q;
      assign nv_extref_w[g] = extref_e_q;
      assign nv_vsrc_w[2*g +: 2] = vsrc_e_q;
      assign nv_isrc_w[2*g +: 2] = isrc_e_q;
      assign nv_vlim_w[LIM_W*g +: LIM_W] = vlim_e_q;
      assign nv_ilim_w[LIM_W*g +: LIM_W] = ilim_e_q;
    end
  endgenerate

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cfg_done_q <= 1'b0;
      cur_mode_q <= 1'b0;
      mode_follow_q <= 1'b0;
      extref_q <= 1'b0;
      extref_ok_q <= 1'b0;
      vsrc_q <= `PUSEL_PROT_FIXED;
      isrc_q <= `PUSEL_PROT_FIXED;
      fixed_q <= 2'h0;
      fixed_en_q <= 1'b0;
      outctl_q <= `PUSEL_OUTCTL_TRIG;
      out_cmd_q <= 1'b0;
      vlim_q <= `PUSEL_LIM_RATED;
      ilim_q <= `PUSEL_LIM_RATED;
      swlim_q <= `PUSEL_LIM_RATED;
      dsetpt_q <= {LIM_W{1'b0}};
      arg_q <= 4'h0;
    end else if (i_ce) begin
      if (!cfg_done_q) begin
        cfg_done_q <= 1'b1;
        outctl_q <= nv_outctl_q;
        if (i_reset_power_up) begin
          swlim_q <= `PUSEL_LIM_RATED;
          nv_swlim_q <= `PUSEL_LIM_RATED;
          nv_outctl_q <= `PUSEL_OUTCTL_TRIG;
          outctl_q <= `PUSEL_OUTCTL_TRIG;
        end else
          swlim_q <= nv_swlim_q;
        extref_ok_q <= (sw == 5'h00) || (sw[1] && sw[4]);
        fixed_en_q <= 1'b0;
        if (sw == 5'h00) begin
          // mode from pin; analog limits and reference
          mode_follow_q <= 1'b1;
          extref_q <= 1'b1;
          vsrc_q <= `PUSEL_PROT_EXT;
          isrc_q <= `PUSEL_PROT_EXT;
        end else if (!sw[4]) begin
          // restore location; a reset power-up keeps the defaults instead
          if (!i_reset_power_up) begin
            cur_mode_q <= nv_mode_w[loc];
            mode_follow_q <= nv_mfollow_w[loc];
            extref_q <= nv_extref_w[loc];
            vsrc_q <= nv_vsrc_w[2*loc +: 2];
            isrc_q <= nv_isrc_w[2*loc +: 2];
            vlim_q <= nv_vlim_w[LIM_W*loc +: LIM_W];
            ilim_q <= nv_ilim_w[LIM_W*loc +: LIM_W];
          end
        end else begin
          cur_mode_q <= !sw[0];
          if (sw[3:2] == 2'b00) begin
            vsrc_q <= `PUSEL_PROT_EXT;
            isrc_q <= `PUSEL_PROT_EXT;
          end else begin
            fixed_en_q <= 1'b1;
            fixed_q <= sw[3:2];
          end
        end
      end else begin
        if (i_avs_write && !o_avs_waitrequest && i_avs_address == `PUSEL_REG_ARG)
          arg_q <= i_avs_writedata[3:0];
        if (i_avs_write && !o_avs_waitrequest && i_avs_address == `PUSEL_REG_VLIM)
          vlim_q <= i_avs_writedata[LIM_W-1:0];
        if (i_avs_write && !o_avs_waitrequest && i_avs_address == `PUSEL_REG_ILIM)
          ilim_q <= i_avs_writedata[LIM_W-1:0];
        if (i_avs_write && !o_avs_waitrequest && i_avs_address == `PUSEL_REG_SETPT)
          dsetpt_q <= i_avs_writedata[LIM_W-1:0];
        if (i_avs_write && !o_avs_waitrequest && i_avs_address == `PUSEL_REG_SWLIM)
          swlim_q <= i_avs_writedata[LIM_W-1:0];
        if (cmd_wr) begin
          case (cmd)
            `PUSEL_CMD_OUT_ON: begin
              out_cmd_q <= 1'b1;
            end
            `PUSEL_CMD_OUT_OFF: begin
              out_cmd_q <= 1'b0;
            end
            `PUSEL_CMD_OUT_CTRL: begin
              outctl_q <= arg_q[0];
            end
            `PUSEL_CMD_MODE: begin
              mode_follow_q <= (arg_q[1:0] == `PUSEL_ARG_OUTSIDE);
              if (arg_q[1:0] != `PUSEL_ARG_OUTSIDE)
                cur_mode_q <= (arg_q[1:0] == `PUSEL_ARG_CURR);
            end
            `PUSEL_CMD_VPROT_SRC: begin
              vsrc_q <= arg_q[1:0];
              fixed_en_q <= 1'b0;
            end
            `PUSEL_CMD_IPROT_SRC: begin
              isrc_q <= arg_q[1:0];
              fixed_en_q <= 1'b0;
            end
            `PUSEL_CMD_MAIN_SRC: begin
              extref_q <= (arg_q[1:0] == `PUSEL_ARG_OUTSIDE);
            end
            `PUSEL_CMD_SAVE_INT: begin
              nv_outctl_q <= outctl_q;
            end
            `PUSEL_CMD_SAVE_LIM: begin
              nv_swlim_q <= swlim_q;
            end
            // Save location is taken by the per-location copies
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Effective mode: pin high or open selects voltage
  wire mode_eff = mode_follow_q ? !mpin_q : cur_mode_q;
  // trigger pin high or open turns output off; commands only otherwise
  wire out_eff = outctl_q ? !trig_q : out_cmd_q;
  wire use_ext = extref_q && extref_ok_q;

  // digital limit, analog limit, or lesser of the two, by protect source
  function [LIM_W-1:0] pick;
    input [1:0] src;
    input [LIM_W-1:0] dig;
    input [LIM_W-1:0] ana;
    begin
      case (src)
        `PUSEL_PROT_EXT: pick = ana;
        `PUSEL_PROT_LESS: pick = (ana < dig) ? ana : dig;
        default: pick = dig;
      endcase
    end
  endfunction

  // only the limit pair of the active protect channel is used
  wire [1:0] psrc = mode_eff ? vsrc_q : isrc_q;
  wire [LIM_W-1:0] pdig = mode_eff ? vlim_q : ilim_q;
  wire [LIM_W-1:0] apos = mode_eff ? i_ext_vlim_pos : i_ext_ilim_pos;
  wire [LIM_W-1:0] aneg = mode_eff ? i_ext_vlim_neg : i_ext_ilim_neg;
  reg [LIM_W-1:0] ppos_d;
  reg [LIM_W-1:0] pneg_d;
  always @* begin
    ppos_d = pick(psrc, pdig, apos);
    pneg_d = pick(psrc, pdig, aneg);
    if (fixed_en_q) begin
      ppos_d = fixed_q[1] ? `PUSEL_LIM_MAX : `PUSEL_LIM_MIN;
      pneg_d = fixed_q[0] ? `PUSEL_LIM_MAX : `PUSEL_LIM_MIN;
    end
  end

  // clamp main channel to software limit
  wire signed [LIM_W-1:0] ref_raw = use_ext ? i_ext_reference : dsetpt_q;
  wire signed [LIM_W:0] ref_w = {ref_raw[LIM_W-1], ref_raw};
  wire signed [LIM_W:0] lim_w = {1'b0, swlim_q};
  reg signed [LIM_W-1:0] setpt_d;
  always @* begin
    if (ref_w > lim_w)
      setpt_d = swlim_q;
    else if (ref_w < -lim_w)
      setpt_d = -swlim_q;
    else
      setpt_d = ref_raw;
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_output_on <= 1'b0;
      o_current_mode <= 1'b0;
      o_ext_reference_used <= 1'b0;
      o_setpoint <= {LIM_W{1'b0}};
      o_prot_pos <= `PUSEL_LIM_MIN;
      o_prot_neg <= `PUSEL_LIM_MIN;
    end else if (i_ce && cfg_done_q) begin
      o_output_on <= out_eff;
      o_current_mode <= mode_eff;
      o_ext_reference_used <= use_ext;
      o_setpoint <= setpt_d;
      o_prot_pos <= ppos_d;
      o_prot_neg <= pneg_d;
    end
  end

  // Avalon slave: one wait cycle per access, then the answer
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (i_avs_address)
      `PUSEL_REG_ARG: rd_d = {28'h0, arg_q};
      `PUSEL_REG_VLIM: rd_d = {{(32-LIM_W){1'b0}}, vlim_q};
      `PUSEL_REG_ILIM: rd_d = {{(32-LIM_W){1'b0}}, ilim_q};
      `PUSEL_REG_STATUS: begin
        rd_d[`PUSEL_ST_MODE] = mode_eff;
        rd_d[`PUSEL_ST_OUT] = out_eff;
        rd_d[`PUSEL_ST_TRIG] = outctl_q;
        rd_d[`PUSEL_ST_EXTREF] = use_ext;
        rd_d[`PUSEL_ST_EXTOK] = extref_ok_q;
      end
      `PUSEL_REG_VOUT: rd_d = {{(32-LIM_W){1'b0}}, ppos_d};
      `PUSEL_REG_IOUT: rd_d = {{(32-LIM_W){1'b0}}, pneg_d};
      `PUSEL_REG_SETPT: rd_d = {{(32-LIM_W){1'b0}}, dsetpt_q};
      `PUSEL_REG_SWLIM: rd_d = {{(32-LIM_W){1'b0}}, swlim_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce) begin
      // Wait stays high until configuration is taken, so no command races it
      o_avs_waitrequest <= !(cfg_done_q && (i_avs_read || i_avs_write) && o_avs_waitrequest);
      if (cfg_done_q && i_avs_read && o_avs_waitrequest)
        o_avs_readdata <= rd_d;
    end
  end
endmodule
`default_nettype wire

/* File: sim/pusel_analog_port.sv */
`timescale 1ns/1ps
`default_nettype none
module pusel_analog_port (
  input wire logic i_trig_short,
  input wire logic i_mode_short,
  output logic o_trigger_pin,
  output logic o_mode_pin,
  output logic [15:0] o_vlim_pos,
  output logic [15:0] o_vlim_neg,
  output logic [15:0] o_ilim_pos,
  output logic [15:0] o_ilim_neg,
  output logic [15:0] o_reference
);
  assign o_trigger_pin = !i_trig_short;
  assign o_mode_pin = !i_mode_short;
  assign o_vlim_pos = 16'h1000;
  assign o_vlim_neg = 16'h1100;
  assign o_ilim_pos = 16'h1200;
  assign o_ilim_neg = 16'h1300;
  assign o_reference = 16'h0800;
endmodule
`default_nettype wire

/* File: sim/pusel_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pusel_monitor #(
  parameter LIM_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [4:0] i_power_up_switch_bank,
  input wire logic o_ext_reference_used,
  input wire logic [LIM_W-1:0] o_prot_pos,
  input wire logic [LIM_W-1:0] o_prot_neg
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Acknowledge lasts a single cycle
  property p_wait_pulse;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_wait_cause;
    !(i_avs_read || i_avs_write) |=> o_avs_waitrequest;
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("acknowledge without request");
  property p_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |-> ##[1:3] !o_avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_read_hold;
    !i_avs_read |=> $stable(o_avs_readdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("readdata changed without read");
  property p_high_zero;
    i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("readdata upper half not zero");
  property p_unmapped;
    i_avs_read && !o_avs_waitrequest && i_avs_address > 6'h20 |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_extref;
    o_ext_reference_used |->
      i_power_up_switch_bank == 5'h00 || (i_power_up_switch_bank[1] && i_power_up_switch_bank[4]);
  endproperty
  a_extref: assert property (p_extref) else $error("reference used without switches");
  property p_prot_cap;
    o_prot_pos <= 16'h2774 && o_prot_neg <= 16'h2774;
  endproperty
  a_prot_cap: assert property (p_prot_cap) else $error("protect limit above maximum");
endmodule
`default_nettype wire

/* File: sim/test_power_up_source_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pusel_defs.vh"
module test_power_up_source_select;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [4:0] sw = 5'h00;
  logic tshort = 1'b0;
  logic mshort = 1'b0;
  logic rpu = 1'b1;
  logic [31:0] q;
  wire [31:0] rdata;
  wire waitreq, tpin, mpin, out_on, cur, ext_used;
  wire [15:0] vp, vn, ip, ineg, rf, setpt, ppos, pneg;
  integer err_total = 0;
  integer cmp_count = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  pusel_analog_port pusel_analog_port_inst (.i_trig_short(tshort), .i_mode_short(mshort),
    .o_trigger_pin(tpin), .o_mode_pin(mpin), .o_vlim_pos(vp), .o_vlim_neg(vn),
    .o_ilim_pos(ip), .o_ilim_neg(ineg), .o_reference(rf));
  pusel_top pusel_top_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_power_up_switch_bank(sw),
    .i_reset_power_up(rpu), .i_trigger_pin(tpin), .i_mode_pin(mpin),
    .i_ext_vlim_pos(vp), .i_ext_vlim_neg(vn), .i_ext_ilim_pos(ip), .i_ext_ilim_neg(ineg),
    .i_ext_reference(rf), .o_output_on(out_on), .o_current_mode(cur),
    .o_ext_reference_used(ext_used), .o_setpoint(setpt), .o_prot_pos(ppos), .o_prot_neg(pneg));
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) chk("bus answer", 32'h0, 32'h1);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] arg);
    bus(1'b1, `PUSEL_REG_ARG, {30'h0, arg});
    bus(1'b1, `PUSEL_REG_CMD, {28'h0, c});
  endtask
  task automatic pwr(input logic [4:0] s);
    @(posedge clk);
    rst_n <= 1'b0;
    sw <= s;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // A pin held low across reset needs all three synchroniser stages after release
    repeat (8) @(posedge clk);
  endtask
  initial begin : main
    logic [4:0] tsw [4];
    logic [15:0] tpos [4];
    logic [15:0] tneg [4];
    tsw = '{5'h11, 5'h15, 5'h19, 5'h1D};
    tpos = '{16'h1200, `PUSEL_LIM_MIN, `PUSEL_LIM_MAX, `PUSEL_LIM_MAX};
    tneg = '{16'h1300, `PUSEL_LIM_MAX, `PUSEL_LIM_MIN, `PUSEL_LIM_MAX};
    // Voltage mode shows the current pair
    for (int k = 0; k < 4; k++) begin
      pwr(tsw[k]);
      chk("current mode", 32'h0, {31'h0, cur});
      chk("prot pos", {16'h0, tpos[k]}, {16'h0, ppos});
      chk("prot neg", {16'h0, tneg[k]}, {16'h0, pneg});
    end
    pwr(5'h10);
    chk("current mode", 32'h1, {31'h0, cur});
    chk("prot pos", 32'h1000, {16'h0, ppos});
    chk("ext ref used", 32'h0, {31'h0, ext_used});
    chk("output open pin", 32'h0, {31'h0, out_on});
    tshort <= 1'b1;
    repeat (6) @(posedge clk);
    chk("output shorted pin", 32'h1, {31'h0, out_on});
    cmd(`PUSEL_CMD_OUT_OFF, 2'h0);
    chk("output pin priority", 32'h1, {31'h0, out_on});
    cmd(`PUSEL_CMD_OUT_CTRL, 2'h0);
    cmd(`PUSEL_CMD_OUT_OFF, 2'h0);
    chk("output command off", 32'h0, {31'h0, out_on});
    cmd(`PUSEL_CMD_OUT_ON, 2'h0);
    tshort <= 1'b0;
    repeat (6) @(posedge clk);
    chk("output command on", 32'h1, {31'h0, out_on});
    cmd(`PUSEL_CMD_MODE, `PUSEL_ARG_VOLT);
    chk("mode volt", 32'h0, {31'h0, cur});
    cmd(`PUSEL_CMD_MODE, `PUSEL_ARG_CURR);
    chk("mode curr", 32'h1, {31'h0, cur});
    cmd(`PUSEL_CMD_MODE, `PUSEL_ARG_OUTSIDE);
    chk("mode pin open", 32'h0, {31'h0, cur});
    mshort <= 1'b1;
    repeat (6) @(posedge clk);
    chk("mode pin short", 32'h1, {31'h0, cur});
    bus(1'b1, `PUSEL_REG_VLIM, 32'h0500);
    cmd(`PUSEL_CMD_VPROT_SRC, `PUSEL_PROT_FIXED);
    chk("fixed prot", 32'h0500, {16'h0, pneg});
    cmd(`PUSEL_CMD_VPROT_SRC, `PUSEL_PROT_LESS);
    bus(1'b1, `PUSEL_REG_VLIM, 32'h1080);
    chk("lesser pos", 32'h1000, {16'h0, ppos});
    chk("lesser neg", 32'h1080, {16'h0, pneg});
    cmd(`PUSEL_CMD_VPROT_SRC, `PUSEL_PROT_EXT);
    chk("outside neg", 32'h1100, {16'h0, pneg});
    pwr(5'h00);
    chk("analog mode pin", 32'h1, {31'h0, cur});
    chk("analog ref used", 32'h1, {31'h0, ext_used});
    cmd(`PUSEL_CMD_MAIN_SRC, 2'h0);
    chk("digital main", 32'h0, {31'h0, ext_used});
    cmd(`PUSEL_CMD_MAIN_SRC, `PUSEL_ARG_OUTSIDE);
    chk("outside main", 32'h1, {31'h0, ext_used});
    chk("setpoint follows", 32'h0800, {16'h0, setpt});
    bus(1'b1, `PUSEL_REG_SWLIM, 32'h0400);
    chk("setpoint clamp", 32'h0400, {16'h0, setpt});
    cmd(`PUSEL_CMD_MODE, `PUSEL_ARG_CURR);
    bus(1'b1, `PUSEL_REG_VLIM, 32'h0600);
    cmd(`PUSEL_CMD_VPROT_SRC, `PUSEL_PROT_FIXED);
    cmd(`PUSEL_CMD_SAVE_LOC, 2'h3);
    cmd(`PUSEL_CMD_SAVE_LIM, 2'h0);
    cmd(`PUSEL_CMD_OUT_CTRL, 2'h0);
    cmd(`PUSEL_CMD_SAVE_INT, 2'h0);
    rpu <= 1'b0;
    pwr(5'h03);
    chk("saved mode", 32'h1, {31'h0, cur});
    chk("saved prot", 32'h0600, {16'h0, ppos});
    bus(1'b0, `PUSEL_REG_STATUS, 32'h0);
    chk("saved trig ctl", 32'h0, {31'h0, q[`PUSEL_ST_TRIG]});
    bus(1'b0, `PUSEL_REG_SWLIM, 32'h0);
    chk("saved sw limit", 32'h0400, q);
    rpu <= 1'b1;
    pwr(5'h03);
    bus(1'b0, `PUSEL_REG_SWLIM, 32'h0);
    chk("factory sw limit", {16'h0, `PUSEL_LIM_RATED}, q);
    bus(1'b0, `PUSEL_REG_STATUS, 32'h0);
    chk("factory trig ctl", 32'h1, {31'h0, q[`PUSEL_ST_TRIG]});
    bus(1'b0, 6'h3C, 32'h0);
    chk("unmapped read", 32'h0, q);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
bind pusel_top pusel_monitor #(.LIM_W(LIM_W)) pusel_monitor_inst (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_power_up_switch_bank(i_power_up_switch_bank),
  .o_ext_reference_used(o_ext_reference_used), .o_prot_pos(o_prot_pos),
  .o_prot_neg(o_prot_neg));
`default_nettype wire
